// ==== pkg/oscc_pkg.sv ====
// Constants, types and register layout of the oscillator select control block.
package oscc_pkg;
   // =========================================================
   // Register byte offsets
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_STATUS  = 4'h4;
   localparam logic [3:0] ADDR_MASK    = 4'h8;
   localparam logic [3:0] ADDR_UNLOCK  = 4'hc;
   // =========================================================
   // Control register field positions
   localparam int CUR_LO     = 12;
   localparam int REQ_LO     = 8;
   localparam int SEL_LOCK   = 7;
   localparam int PIN_LOCK   = 6;
   localparam int PLL_STAT   = 5;
   localparam int FAIL_FLAG  = 3;
   localparam int PRI_KEEP   = 2;
   localparam int SEC_EN     = 1;
   localparam int SW_REQ     = 0;
   // =========================================================
   // Event bits shared by the status and mask registers
   localparam int EV_SWITCH  = 0;
   localparam int EV_FAIL    = 1;
   localparam int EV_PLL     = 2;
   localparam int EV_W       = 3;
   // =========================================================
   // Source encodings
   localparam logic [2:0] SRC_FAST_RC_POST     = 3'h7;
   localparam logic [2:0] SRC_FAST_RC_DIV16    = 3'h6;
   localparam logic [2:0] SRC_LOW_POWER_RC     = 3'h5;
   localparam logic [2:0] SRC_SECONDARY        = 3'h4;
   localparam logic [2:0] SRC_PRIMARY_PLL      = 3'h3;
   localparam logic [2:0] SRC_PRIMARY          = 3'h2;
   localparam logic [2:0] SRC_FAST_RC_POST_PLL = 3'h1;
   localparam logic [2:0] SRC_FAST_RC          = 3'h0;
   // =========================================================
   // Reset values and unlock keys (key values are arbitrary)
   localparam logic [2:0]  RST_SRC     = 3'h0;
   localparam logic [EV_W-1:0] RST_EV  = 3'h0;
   localparam logic [15:0] UNLOCK_KEY1 = 16'h005a;
   localparam logic [15:0] UNLOCK_KEY2 = 16'h00a5;
   localparam logic [1:0]  MON_ALL_ON  = 2'h0;
   // =========================================================
   // Types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } oscc_state_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [3:0]  paddr;
      logic [31:0] pwdata;
   } oscc_apb_req_t;
   typedef struct packed {
      logic [2:0] initial_source_cfg;
      logic [1:0] primary_mode_cfg;
      logic [1:0] switch_monitor_cfg;
      logic       pin_map_lock_one_way;
   } oscc_cfg_t;
endpackage : oscc_pkg

// ==== design/oscc_top.sv ====
// Oscillator select control register, switch sequencer and event interrupt.
// Summary of operation
// - Read-only current source field at bits 14-12, updated by hardware.
// - Three-bit source encoding shared by current and requested fields.
// - Writable requested source field at bits 10-8 for the next switch.
// - Both source fields reset to 0, then load the initial source configuration value on the first enabled edge after reset.
// - Bit 0 starts a switch; hardware clears it when the switch completes.
// - With fail-safe monitor on and selection lock set, switches change nothing.
// - With fail-safe monitor off, selections are never locked.
// - Selection lock at bit 7 resets to 0, software may only set it.
// - Pin-map lock at bit 6 changes only after the unlock sequence.
// - With one-way configuration set, pin-map lock cannot be cleared once set.
// - PLL status at bit 5 reads 1 when PLL locked while a PLL source is current.
// - PLL status clears on every valid switch and in non-PLL modes.
// - Clock-fail flag at bit 3 set on detected failure, cleared by software.
// - Bit 2 keeps the primary oscillator running in Sleep when 1.
// - Bit 1 enables the 32 kHz secondary oscillator, reset value 0.
// - Bits 15, 11 and 4 read as 0 and ignore writes.
// - At power-on the device starts on the configured initial source.
// - Switching needs upper monitor bit 0; fail-safe needs both bits 0.
module oscc_top (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  clk_en_in,
   input  wire oscc_pkg::oscc_apb_req_t apb_in,
   input  wire oscc_pkg::oscc_cfg_t   cfg_in,
   input  wire logic                  pll_locked_in,
   input  wire logic                  clock_fail_in,
   input  wire logic                  switch_ack_in,
   input  wire logic                  sleep_in,
   output logic                       pready_out,
   output logic [31:0]                prdata_out,
   output logic                       pslverr_out,
   output logic [2:0]                 clk_source_out,
   output logic [2:0]                 switch_target_out,
   output logic                       switch_start_out,
   output logic                       primary_run_out,
   output logic                       secondary_osc_enable_out,
   output logic                       pin_map_lock_out,
   output logic                       irq_out
);
   // =========================================================
   // State
   oscc_pkg::oscc_state_t   state_q;
   logic [2:0]              cur_q;
   logic [2:0]              req_q;
   logic                    sel_lock_q;
   logic                    pin_lock_q;
   logic                    pll_stat_q;
   logic                    fail_q;
   logic                    pri_keep_q;
   logic                    sec_en_q;
   logic                    sw_req_q;
   logic                    strap_done_q;
   logic [1:0]              key_stage_q;
   logic [oscc_pkg::EV_W-1:0] status_q;
   logic [oscc_pkg::EV_W-1:0] mask_q;
   logic [oscc_pkg::EV_W-1:0] ev;
   logic                    fire;
   logic                    wr;
   logic [15:0]             wd;
   logic                    sw_allowed;
   logic                    fs_on;
   logic                    locked_eff;
   logic                    cur_is_pll;
   logic                    sw_done;
   logic                    sw_refuse;
   logic [15:0]             ctrl_rd;
   // =========================================================
   // Decode
   assign fire = apb_in.psel && apb_in.penable && pready_out;
   assign wr   = fire && apb_in.pwrite;
   assign wd   = apb_in.pwdata[15:0];
   // Switching is usable only with the upper monitor bit programmed low.
   assign sw_allowed = !cfg_in.switch_monitor_cfg[1];
   assign fs_on      = cfg_in.switch_monitor_cfg == oscc_pkg::MON_ALL_ON;
   // Lock only bites while the fail-safe monitor runs.
   assign locked_eff = fs_on && sel_lock_q;
   assign cur_is_pll = (cur_q == oscc_pkg::SRC_PRIMARY_PLL) ||
                       (cur_q == oscc_pkg::SRC_FAST_RC_POST_PLL);
   assign sw_done   = (state_q == oscc_pkg::ST_WAIT) && switch_ack_in;
   assign sw_refuse = (state_q == oscc_pkg::ST_IDLE) && sw_req_q &&
                      (!sw_allowed || locked_eff);
   assign ev[oscc_pkg::EV_SWITCH] = sw_done;
   assign ev[oscc_pkg::EV_FAIL]   = clock_fail_in && fs_on;
   assign ev[oscc_pkg::EV_PLL]    = pll_locked_in && cur_is_pll && !pll_stat_q &&
                                    state_q == oscc_pkg::ST_IDLE;
   // Unimplemented bits are tied low in the read image.
   assign ctrl_rd = {1'b0, cur_q, 1'b0, req_q, sel_lock_q, pin_lock_q, pll_stat_q,
                     1'b0, fail_q, pri_keep_q, sec_en_q, sw_req_q};
   // =========================================================
   // APB slave: one wait state, registered answer
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0;
         pslverr_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         pready_out  <= apb_in.psel && apb_in.penable && !pready_out;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0;
         if (apb_in.psel && apb_in.penable && !pready_out)
         begin
            unique case (apb_in.paddr)
               oscc_pkg::ADDR_CTRL:   prdata_out <= {16'h0, ctrl_rd};
               oscc_pkg::ADDR_STATUS: prdata_out <= {29'h0, status_q};
               oscc_pkg::ADDR_MASK:   prdata_out <= {29'h0, mask_q};
               oscc_pkg::ADDR_UNLOCK: prdata_out <= 32'h0;
               default:               pslverr_out <= 1'b1;
            endcase
         end
      end
   end
   // =========================================================
   // Source fields and switch sequencer
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         cur_q        <= oscc_pkg::RST_SRC;
         req_q        <= oscc_pkg::RST_SRC;
         strap_done_q <= 1'b0;
         sw_req_q     <= 1'b0;
         state_q      <= oscc_pkg::ST_IDLE;
      end
      else if (clk_en_in)
      begin
         if (!strap_done_q)
         begin
            // Straps are sampled after release; a reset flop may not load a port.
            strap_done_q <= 1'b1;
            cur_q        <= cfg_in.initial_source_cfg;
            req_q        <= cfg_in.initial_source_cfg;
         end
         else
         begin
            if (wr && apb_in.paddr == oscc_pkg::ADDR_CTRL)
            begin
               if (!locked_eff && state_q == oscc_pkg::ST_IDLE)
                  req_q <= wd[oscc_pkg::REQ_LO +: 3];
               if (wd[oscc_pkg::SW_REQ])
                  sw_req_q <= 1'b1;
            end
            unique case (state_q)
               oscc_pkg::ST_IDLE:
               begin
                  if (sw_refuse)
                     sw_req_q <= 1'b0;
                  else if (sw_req_q)
                     state_q <= oscc_pkg::ST_WAIT;
               end
               oscc_pkg::ST_WAIT:
               begin
                  if (switch_ack_in)
                  begin
                     cur_q    <= req_q;
                     sw_req_q <= 1'b0;
                     state_q  <= oscc_pkg::ST_IDLE;
                  end
               end
            endcase
         end
      end
   end
   // =========================================================
   // Lock bits and unlock sequence
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sel_lock_q  <= 1'b0;
         pin_lock_q  <= 1'b0;
         key_stage_q <= 2'h0;
      end
      else if (clk_en_in && wr)
      begin
         if (apb_in.paddr == oscc_pkg::ADDR_UNLOCK)
         begin
            if (wd == oscc_pkg::UNLOCK_KEY1)
               key_stage_q <= 2'h1;
            else if (wd == oscc_pkg::UNLOCK_KEY2 && key_stage_q == 2'h1)
               key_stage_q <= 2'h2;
            else
               key_stage_q <= 2'h0;
         end
         else
         begin
            // Any other write closes the window, so a stray access cannot reuse it.
            key_stage_q <= 2'h0;
         end
         if (apb_in.paddr == oscc_pkg::ADDR_CTRL)
         begin
            if (wd[oscc_pkg::SEL_LOCK])
               sel_lock_q <= 1'b1;
            if (key_stage_q == 2'h2 &&
                !(cfg_in.pin_map_lock_one_way && pin_lock_q))
               pin_lock_q <= wd[oscc_pkg::PIN_LOCK];
         end
      end
   end
   // =========================================================
   // Oscillator enables, PLL status and fail flag
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pri_keep_q <= 1'b0;
         sec_en_q   <= 1'b0;
         pll_stat_q <= 1'b0;
         fail_q     <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (wr && apb_in.paddr == oscc_pkg::ADDR_CTRL)
         begin
            pri_keep_q <= wd[oscc_pkg::PRI_KEEP];
            sec_en_q   <= wd[oscc_pkg::SEC_EN];
         end
         if (state_q == oscc_pkg::ST_WAIT || !cur_is_pll)
            pll_stat_q <= 1'b0;
         else
            pll_stat_q <= pll_locked_in;
         // A detected failure wins over a clear in the same cycle.
         if (ev[oscc_pkg::EV_FAIL])
            fail_q <= 1'b1;
         else if (wr && apb_in.paddr == oscc_pkg::ADDR_CTRL && !wd[oscc_pkg::FAIL_FLAG])
            fail_q <= 1'b0;
      end
   end
   // =========================================================
   // Interrupt status, mask and output
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         status_q <= oscc_pkg::RST_EV;
         mask_q   <= oscc_pkg::RST_EV;
         irq_out  <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (wr && apb_in.paddr == oscc_pkg::ADDR_STATUS)
            status_q <= (status_q & ~wd[oscc_pkg::EV_W-1:0]) | ev;
         else
            status_q <= status_q | ev;
         if (wr && apb_in.paddr == oscc_pkg::ADDR_MASK)
            mask_q <= wd[oscc_pkg::EV_W-1:0];
         irq_out <= |(status_q & mask_q);
      end
   end
   // =========================================================
   // Outputs toward the clock tree
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         clk_source_out           <= oscc_pkg::RST_SRC;
         switch_target_out        <= oscc_pkg::RST_SRC;
         switch_start_out         <= 1'b0;
         primary_run_out          <= 1'b1;
         secondary_osc_enable_out <= 1'b0;
         pin_map_lock_out         <= 1'b0;
      end
      else if (clk_en_in)
      begin
         clk_source_out           <= cur_q;
         switch_target_out        <= req_q;
         switch_start_out         <= state_q == oscc_pkg::ST_WAIT && !switch_ack_in;
         primary_run_out          <= !sleep_in || pri_keep_q;
         secondary_osc_enable_out <= sec_en_q;
         pin_map_lock_out         <= pin_lock_q;
      end
   end
   // =========================================================
   // Checks
   // Every check is muted during reset, since the straps reload on the first edge after it.
   a_apb_ready_once: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && apb_in.psel && apb_in.penable && !pready_out |=> pready_out)
      else $error("pready did not follow access phase");

   a_reserved_read_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      pready_out |-> prdata_out[31:16] == 16'h0 && !prdata_out[15] &&
      !prdata_out[11] && !prdata_out[4])
      else $error("reserved bits read nonzero");

   a_sel_lock_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_lock_q |=> sel_lock_q)
      else $error("selection lock cleared");

   a_locked_no_change: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      strap_done_q && locked_eff && state_q == oscc_pkg::ST_IDLE |=> $stable(cur_q))
      else $error("locked source changed");

   a_req_locked_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && strap_done_q && locked_eff |=> $stable(req_q))
      else $error("locked request field changed");

   a_switch_complete: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && sw_done |=> !sw_req_q && cur_q == $past(req_q))
      else $error("switch did not complete");

   a_switch_event: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && sw_done |=> status_q[oscc_pkg::EV_SWITCH])
      else $error("switch done not flagged");

   a_start_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> switch_start_out ==
      ($past(state_q) == oscc_pkg::ST_WAIT && !$past(switch_ack_in)))
      else $error("switch start output wrong");

   a_refuse_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && strap_done_q && sw_refuse |=> !sw_req_q && $stable(cur_q) &&
      state_q == oscc_pkg::ST_IDLE)
      else $error("refused switch not dropped");

   a_pll_nonpll_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && (!cur_is_pll || state_q == oscc_pkg::ST_WAIT) |=> !pll_stat_q)
      else $error("pll status high outside pll mode");

   a_pll_stat_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && cur_is_pll && state_q == oscc_pkg::ST_IDLE |=>
      pll_stat_q == $past(pll_locked_in))
      else $error("pll status does not follow lock");

   a_pll_event: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && ev[oscc_pkg::EV_PLL] |=> status_q[oscc_pkg::EV_PLL])
      else $error("pll lock not flagged");

   a_fail_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && clock_fail_in && fs_on |=> fail_q && status_q[oscc_pkg::EV_FAIL])
      else $error("clock fail not flagged");

   a_fail_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && wr && apb_in.paddr == oscc_pkg::ADDR_CTRL &&
      !wd[oscc_pkg::FAIL_FLAG] && !ev[oscc_pkg::EV_FAIL] |=> !fail_q)
      else $error("clock fail not cleared");

   a_one_way_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      cfg_in.pin_map_lock_one_way && pin_lock_q |=> pin_lock_q)
      else $error("one-way pin lock cleared");

   a_pin_lock_guard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      key_stage_q != 2'h2 |=> $stable(pin_lock_q))
      else $error("pin lock changed without unlock");

   a_pin_out_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> pin_map_lock_out == $past(pin_lock_q))
      else $error("pin lock output wrong");

   a_source_out_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> clk_source_out == $past(cur_q))
      else $error("source output wrong");

   a_target_out_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> switch_target_out == $past(req_q))
      else $error("target output wrong");

   a_primary_run: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> primary_run_out == (!$past(sleep_in) || $past(pri_keep_q)))
      else $error("primary run output wrong");

   a_secondary_en: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> secondary_osc_enable_out == $past(sec_en_q))
      else $error("secondary enable output wrong");

   a_freeze_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !clk_en_in |=> $stable(cur_q) && $stable(status_q) && $stable(pready_out))
      else $error("state moved while frozen");

   a_irq_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in |=> irq_out == |($past(status_q) & $past(mask_q)))
      else $error("irq does not follow masked status");
endmodule : oscc_top

// ==== tb/oscillator_select_control_tb_top.sv ====
// Self-checking testbench of the oscillator select control block.
module oscillator_select_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================================
   // Signals and counters
   localparam logic [3:0]   AC = oscc_pkg::ADDR_CTRL;
   localparam logic [3:0]   AS = oscc_pkg::ADDR_STATUS;
   localparam logic [3:0]   AM = oscc_pkg::ADDR_MASK;
   localparam logic [3:0]   AU = oscc_pkg::ADDR_UNLOCK;
   logic                    clk_in = 1'b0;
   logic                    sys_rst_in = 1'b1;
   oscc_pkg::oscc_apb_req_t apb_in = '0;
   oscc_pkg::oscc_cfg_t     cfg_in = '0;
   logic                    pll_locked_in = 1'b0;
   logic                    clock_fail_in = 1'b0;
   logic                    switch_ack_in = 1'b0;
   logic                    sleep_in = 1'b0;
   logic                    clk_en_in = 1'b1;
   logic                    pready_out, pslverr_out, switch_start_out, primary_run_out;
   logic                    secondary_osc_enable_out, pin_map_lock_out, irq_out;
   logic [31:0]             prdata_out, rd;
   logic [2:0]              clk_source_out, switch_target_out;
   logic                    err;
   int                      error_cnt = 0;
   int                      comparisons = 0;
   int                      cycles = 0;

   always #2.5 clk_in = ~clk_in;

   oscc_top oscc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
      .apb_in(apb_in), .cfg_in(cfg_in), .pll_locked_in(pll_locked_in),
      .clock_fail_in(clock_fail_in), .switch_ack_in(switch_ack_in), .sleep_in(sleep_in),
      .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .clk_source_out(clk_source_out), .switch_target_out(switch_target_out),
      .switch_start_out(switch_start_out), .primary_run_out(primary_run_out),
      .secondary_osc_enable_out(secondary_osc_enable_out),
      .pin_map_lock_out(pin_map_lock_out), .irq_out(irq_out));

   // =========================================================
   // Shared tasks
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] ctl(input logic [2:0] c, input logic [2:0] r,
                                       input logic [7:0] lo);
      return {16'h0000, 1'b0, c, 1'b0, r, lo};
   endfunction : ctl

   // The answer is taken at the rising edge where pready is sampled high; only the
   // bench timeout ends a wait, since the master assumes no fixed wait count.
   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_in);
      apb_in <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clk_in);
      apb_in.penable <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1)
         @(posedge clk_in);
      rd = prdata_out;
      err = pslverr_out;
      apb_in <= '0;
   endtask : apb

   task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask : rchk

   task automatic rst(input logic [2:0] src, input logic [1:0] mon, input logic ow);
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      cfg_in <= '{src, 2'h0, mon, ow};
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : rst

   task automatic pulse_fail();
      clock_fail_in <= 1'b1;
      @(posedge clk_in);
      clock_fail_in <= 1'b0;
      repeat (2) @(negedge clk_in);
   endtask : pulse_fail

   task automatic keys();
      apb(1'b1, AU, oscc_pkg::UNLOCK_KEY1);
      apb(1'b1, AU, oscc_pkg::UNLOCK_KEY2);
   endtask : keys

   task automatic sw(input logic [2:0] src, input logic ok);
      int n;
      n = 0;
      apb(1'b1, AC, {21'h0, src, 8'h01});
      repeat (3) @(negedge clk_in);
      while (ok && switch_start_out !== 1'b1 && n < 10)
      begin
         n++;
         @(negedge clk_in);
      end
      chk("switch_start_out", {31'h0, switch_start_out}, {31'h0, ok});
      if (ok)
      begin
         chk("switch_target_out", {29'h0, switch_target_out}, {29'h0, src});
         @(posedge clk_in);
         switch_ack_in <= 1'b1;
         @(posedge clk_in);
         switch_ack_in <= 1'b0;
      end
      repeat (3) @(negedge clk_in);
   endtask : sw

   // =========================================================
   // Scenarios
   task automatic t_basic();
      rchk(AC, ctl(3'h6, 3'h6, 8'h00), "ctrl after reset");
      chk("clk_source_out", {29'h0, clk_source_out}, 32'h6);
      apb(1'b1, AC, 32'h0000_f816);
      rchk(AC, ctl(3'h6, 3'h0, 8'h06), "ctrl reserved bits");
      chk("secondary enable", {31'h0, secondary_osc_enable_out}, 32'h1);
      sleep_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      chk("primary run kept", {31'h0, primary_run_out}, 32'h1);
      apb(1'b1, AC, 32'h0);
      repeat (2) @(negedge clk_in);
      chk("primary run stopped", {31'h0, primary_run_out}, 32'h0);
      chk("secondary disable", {31'h0, secondary_osc_enable_out}, 32'h0);
      @(posedge clk_in);
      sleep_in <= 1'b0;
      apb(1'b0, 4'h2, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b1, AM, 32'hffff_ffff);
      rchk(AM, 32'h7, "mask");
      rchk(AU, 32'h0, "unlock read");
   endtask : t_basic

   task automatic t_switch();
      pll_locked_in <= 1'b1;
      sw(3'h3, 1'b1);
      rchk(AC, ctl(3'h3, 3'h3, 8'h20), "ctrl pll switch");
      chk("clk_source_out", {29'h0, clk_source_out}, 32'h3);
      rchk(AS, 32'h5, "status switch");
      chk("irq set", {31'h0, irq_out}, 32'h1);
      apb(1'b1, AS, 32'h5);
      repeat (2) @(negedge clk_in);
      chk("irq cleared", {31'h0, irq_out}, 32'h0);
      sw(3'h2, 1'b1);
      rchk(AC, ctl(3'h2, 3'h2, 8'h00), "ctrl non pll");
      pll_locked_in <= 1'b0;
   endtask : t_switch

   task automatic t_lock();
      rst(3'h6, 2'h0, 1'b0);
      apb(1'b1, AC, 32'h0680);
      apb(1'b1, AC, 32'h0000);
      rchk(AC, ctl(3'h6, 3'h6, 8'h80), "lock sticky");
      sw(3'h4, 1'b0);
      rchk(AC, ctl(3'h6, 3'h6, 8'h80), "locked switch");
      pulse_fail();
      rchk(AC, ctl(3'h6, 3'h6, 8'h88), "fail flag");
      rchk(AS, 32'h2, "fail status");
      apb(1'b1, AC, 32'h0680);
      rchk(AC, ctl(3'h6, 3'h6, 8'h80), "fail cleared");
      clk_en_in <= 1'b0;
      pulse_fail();
      @(posedge clk_in);
      clk_en_in <= 1'b1;
      rchk(AC, ctl(3'h6, 3'h6, 8'h80), "frozen fail ignored");
   endtask : t_lock

   task automatic t_free();
      rst(3'h6, 2'h1, 1'b0);
      apb(1'b1, AM, 32'h0);
      apb(1'b1, AC, 32'h0680);
      sw(3'h4, 1'b1);
      rchk(AC, ctl(3'h4, 3'h4, 8'h80), "unlocked switch");
      chk("irq masked", {31'h0, irq_out}, 32'h0);
      pulse_fail();
      rchk(AC, ctl(3'h4, 3'h4, 8'h80), "fail ignored");
   endtask : t_free

   task automatic t_nosw();
      rst(3'h6, 2'h2, 1'b0);
      sw(3'h5, 1'b0);
      rchk(AC, ctl(3'h6, 3'h5, 8'h00), "switching off");
   endtask : t_nosw

   task automatic t_pin();
      rst(3'h6, 2'h1, 1'b1);
      apb(1'b1, AC, 32'h0640);
      rchk(AC, ctl(3'h6, 3'h6, 8'h00), "pin lock no keys");
      keys();
      apb(1'b1, AC, 32'h0640);
      rchk(AC, ctl(3'h6, 3'h6, 8'h40), "pin lock set");
      chk("pin lock out", {31'h0, pin_map_lock_out}, 32'h1);
      keys();
      apb(1'b1, AC, 32'h0600);
      rchk(AC, ctl(3'h6, 3'h6, 8'h40), "pin lock one way");
      rst(3'h6, 2'h1, 1'b0);
      keys();
      apb(1'b1, AC, 32'h0640);
      keys();
      apb(1'b1, AC, 32'h0600);
      repeat (2) @(negedge clk_in);
      chk("pin lock cleared", {31'h0, pin_map_lock_out}, 32'h0);
   endtask : t_pin

   initial
   begin
      rst(3'h6, 2'h1, 1'b0);
      t_basic();
      t_switch();
      t_lock();
      t_free();
      t_nosw();
      t_pin();
      end_of_test();
   end
endmodule : oscillator_select_control_tb_top
